// ==== bdec_regs.svh ====
// Purpose: offsets, addresses and reset values of the boot and fault control block
// Assumes: 32-bit aligned register words on the bus
// Notes:   definitions only
`ifndef BDEC_REGS_SVH
`define BDEC_REGS_SVH
`define BDEC_OFS_STATUS    8'h00
`define BDEC_OFS_CTRL      8'h04
`define BDEC_OFS_EVAL_A    8'h08
`define BDEC_OFS_EVAL_B    8'h0C
`define BDEC_OFS_EVAL_C    8'h10
`define BDEC_OFS_BOOT_IPTR 8'h14
`define BDEC_CTRL_ERR_SET  0
`define BDEC_CTRL_ERR_CLR  1
`define BDEC_CTRL_HOF_SET  2
`define BDEC_CTRL_HOF_CLR  3
`define BDEC_ROM_BOOT_ADDR 32'h7FFF_FFFE
`define BDEC_USER_BASE     32'h8000_0070
`define BDEC_WORD_RST      32'h0000_0000
`define BDEC_CB_POKE       8'h00
`define BDEC_CB_PEEK       8'h01
`define BDEC_IPTR_FAULT    32'h0000_0002
`define BDEC_IPTR_DEBUG    32'h0000_0001
`endif

// ==== bdec_pkg.sv ====
// Purpose: shared types of the boot and fault control block
// Assumes: four serial links
// Notes:   constants live in bdec_regs.svh
package bdec_pkg;
  localparam int BDEC_LINKS = 4;
  typedef enum logic [3:0] {
    ST_START = 4'h0, ST_ROMWAIT = 4'h1, ST_CTRL = 4'h2, ST_ADDR  = 4'h3,
    ST_DATA  = 4'h4, ST_WRITE   = 4'h5, ST_READ = 4'h6, ST_SEND  = 4'h7,
    ST_LOAD  = 4'h8, ST_STORE   = 4'h9, ST_RUN  = 4'hA, ST_HALT  = 4'hB
  } bdec_state_type;
endpackage

// ==== bdec_top.sv ====
// Purpose: start-up, link boot, peek/poke, debug halt and fault flag control
// Assumes: single hclk domain, AHB-Lite slave, processor and memory on hclk
// Notes:   fault flags and evaluation copies survive hresetn; only por_n clears them
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "bdec_regs.svh"

// Overview of operation
// [R01] sample rom boot select once after reset
// [R02] rom boot starts at top boot address
// [R03] rom boot: low priority, workspace at base
// [R04] link byte accepted within two cycles
// [R05] control byte above one loads bytes upward
// [R06] after last byte run loaded code
// [R07] hold later messages for the processor
// [R08] control zero: address then data, write
// [R09] control one: address, read, send back
// [R10] after access wait for next control byte
// [R11] debug halt stops at descheduling point
// [R12] reset keeps flags; refresh runs while halted
// [R13] halted: inputs finish, outputs fetch nothing
// [R14] controller resets only after halt completes
// [R15] reset under halt skips memory setup
// [R16] after halt boot when halt input falls; only rom boot waits for the fall here, link boot takes a control byte at once
// [R17] halt sets boot and evaluation registers
// [R18] fault pin follows error flag, testerr clears
// [R19] halt on fault only on new error
// [R20] preemption saves flags, clears halt-on-fault
// [R21] fault halt lets links finish, refresh runs
// [R22] halt pointer two or one past instruction
// [R23] user memory base is fixed address
// [R24] words assembled little-endian in memory
// [R25] first received byte is least significant
module bdec_top
  import bdec_pkg::*;
(
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    por_n,
  input  wire logic                    hsel,
  input  wire logic [7:0]              haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic                    hready,
  input  wire logic [31:0]             hwdata,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic                    rom_boot_select,
  input  wire logic                    debug_halt_in,
  input  wire logic [BDEC_LINKS-1:0]   link_rx_valid,
  input  wire logic [8*BDEC_LINKS-1:0] link_rx_data,
  output logic      [BDEC_LINKS-1:0]   link_rx_ready,
  output logic                         link_tx_valid,
  output logic      [1:0]              link_tx_link,
  output logic      [7:0]              link_tx_data,
  input  wire logic                    link_tx_ready,
  output logic                         mem_req,
  output logic                         mem_we,
  output logic      [31:0]             mem_addr,
  output logic      [3:0]              mem_be,
  output logic      [31:0]             mem_wdata,
  input  wire logic [31:0]             mem_rdata,
  input  wire logic                    mem_ack,
  output logic                         mem_setup_start,
  output logic                         refresh_enable,
  output logic                         link_out_fetch_enable,
  output logic                         cpu_start,
  output logic                         cpu_halt,
  output logic                         cpu_halt_request,
  output logic                         cpu_low_priority,
  output logic      [31:0]             cpu_iptr_out,
  output logic      [31:0]             cpu_wptr_out,
  input  wire logic                    cpu_desched,
  input  wire logic [31:0]             cpu_instr_addr_in,
  input  wire logic [31:0]             cpu_wdesc_in,
  input  wire logic                    err_set_in,
  input  wire logic                    testerr_in,
  input  wire logic                    hof_set_in,
  input  wire logic                    hof_clr_in,
  input  wire logic                    preempt_in,
  input  wire logic                    preempt_end_in,
  output logic                         fault_indicator_out
);

  bdec_state_type state_r, state_nxt;
  logic        rom_m_r, rom_s_r, dbg_m_r, dbg_s_r, dbg_d_r, rom_sel_r;
  logic        err_r, hof_r, err_save_r, hof_save_r, err_nxt, hof_nxt;
  logic [1:0]  link_sel_r, first_link, bcnt_r;
  logic        any_valid, rx_fire, op_write_r, halt_pend_r, fault_halt;
  logic [7:0]  rx_byte, count_r, idx_r, byte_r, wr_addr_r;
  logic [31:0] addr_r, data_r, eval_a_r, eval_b_r, eval_c_r;
  logic        wr_pend_r, bus_take, ctrl_wr;
  logic        sw_err_set, sw_err_clr, sw_hof_set, sw_hof_clr;
  // pin syncs run on por_n so the halt level is valid at hresetn release
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      rom_m_r <= 1'b0;
      rom_s_r <= 1'b0;
      dbg_m_r <= 1'b0;
      dbg_s_r <= 1'b0;
      dbg_d_r <= 1'b0;
    end else begin
      rom_m_r <= rom_boot_select;
      rom_s_r <= rom_m_r;
      dbg_m_r <= debug_halt_in;
      dbg_s_r <= dbg_m_r;
      dbg_d_r <= dbg_s_r;
    end
  end
  // bus slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign bus_take  = hsel & htrans[1] & hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= `BDEC_WORD_RST;
    end else begin
      wr_pend_r <= bus_take & hwrite;
      wr_addr_r <= haddr;
      if (bus_take && !hwrite) begin
        unique case (haddr)
          `BDEC_OFS_STATUS:    hrdata <= {20'h0_0000, halt_pend_r, link_sel_r, rom_sel_r,
                                          hof_r, err_r, 2'b00, state_r};
          `BDEC_OFS_EVAL_A:    hrdata <= eval_a_r;
          `BDEC_OFS_EVAL_B:    hrdata <= eval_b_r;
          `BDEC_OFS_EVAL_C:    hrdata <= eval_c_r;
          `BDEC_OFS_BOOT_IPTR: hrdata <= cpu_iptr_out;
          default:             hrdata <= `BDEC_WORD_RST; // unmapped and control read zero
        endcase
      end
    end
  end
  // software flag strobes from the control word
  assign ctrl_wr    = wr_pend_r && wr_addr_r == `BDEC_OFS_CTRL;
  assign sw_err_set = ctrl_wr & hwdata[`BDEC_CTRL_ERR_SET];
  assign sw_err_clr = ctrl_wr & hwdata[`BDEC_CTRL_ERR_CLR];
  assign sw_hof_set = ctrl_wr & hwdata[`BDEC_CTRL_HOF_SET];
  assign sw_hof_clr = ctrl_wr & hwdata[`BDEC_CTRL_HOF_CLR];
  // flag next values; a set beats testerr or a clear strobe in the same cycle; preempt_end_in overrides both flags, preempt_in only the halt-on-fault flag
  always_comb begin
    err_nxt = (err_set_in | sw_err_set) | (err_r & ~(testerr_in | sw_err_clr)); // [R18]
    hof_nxt = (hof_set_in | sw_hof_set) | (hof_r & ~(hof_clr_in | sw_hof_clr));
    if (preempt_end_in) begin
      err_nxt = err_save_r; // [R20]
      hof_nxt = hof_save_r; // [R20]
    end else if (preempt_in) begin
      hof_nxt = 1'b0; // [R20]
    end
  end
  // flags live on por_n only, so hresetn never touches them
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      err_r      <= 1'b0;
      hof_r      <= 1'b0;
      err_save_r <= 1'b0;
      hof_save_r <= 1'b0;
    end else begin
      err_r <= err_nxt; // [R12]
      hof_r <= hof_nxt; // [R12]
      if (preempt_in) begin
        err_save_r <= err_r; // [R20]
        hof_save_r <= hof_r; // [R20]
      end
    end
  end
  assign fault_indicator_out = err_r; // [R18]
  // only a fresh 0 to 1 error while halt-on-fault is already set halts
  assign fault_halt = (state_r == ST_RUN) && err_nxt && !err_r && hof_r; // [R19]
  // lowest numbered link with a byte waiting wins the control byte
  always_comb begin
    first_link = 2'd0;
    any_valid  = 1'b0;
    for (int i = BDEC_LINKS - 1; i >= 0; i--) begin
      if (link_rx_valid[i]) begin
        first_link = 2'(i);
        any_valid  = 1'b1;
      end
    end
  end
  // every link drains while a control byte is awaited, then only the engaged link; others keep messages for the processor
  for (genvar g = 0; g < BDEC_LINKS; g++) begin : g_ready
    assign link_rx_ready[g] = (state_r == ST_CTRL) ||                             // [R04]
                              ((state_r == ST_ADDR || state_r == ST_DATA ||
                                state_r == ST_LOAD) && link_sel_r == 2'(g));      // [R07]
  end
  assign rx_byte = (state_r == ST_CTRL) ? link_rx_data[8*first_link +: 8]
                                        : link_rx_data[8*link_sel_r +: 8];
  assign rx_fire = (state_r == ST_CTRL) ? any_valid : link_rx_valid[link_sel_r];
  // boot sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_START:   state_nxt = rom_s_r ? ST_ROMWAIT : ST_CTRL;            // [R01]
      ST_ROMWAIT: if (!dbg_s_r) state_nxt = ST_RUN;                       // [R16]
      ST_CTRL: begin
        if (rx_fire) begin
          state_nxt = (rx_byte > `BDEC_CB_PEEK) ? ST_LOAD : ST_ADDR;      // [R05]
        end
      end
      ST_ADDR: begin
        if (rx_fire && bcnt_r == 2'd3) begin
          state_nxt = op_write_r ? ST_DATA : ST_READ;                     // [R08]
        end
      end
      ST_DATA:  if (rx_fire && bcnt_r == 2'd3) state_nxt = ST_WRITE;      // [R08]
      ST_WRITE: if (mem_ack) state_nxt = ST_CTRL;                         // [R10]
      ST_READ:  if (mem_ack) state_nxt = ST_SEND;                         // [R09]
      ST_SEND:  if (link_tx_ready && bcnt_r == 2'd3) state_nxt = ST_CTRL; // [R10]
      ST_LOAD:  if (rx_fire) state_nxt = ST_STORE;
      ST_STORE: if (mem_ack) state_nxt = (idx_r + 8'd1 == count_r) ? ST_RUN : ST_LOAD; // [R06]
      ST_RUN: begin
        if (fault_halt || (halt_pend_r && cpu_desched)) state_nxt = ST_HALT; // [R11]
      end
      ST_HALT:  state_nxt = ST_HALT; // left only by hresetn [R14]
      default:  state_nxt = ST_START;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_START;
    end else begin
      state_r <= state_nxt;
    end
  end
  // strap capture, once, on the first edge after release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rom_sel_r <= 1'b0;
    end else if (state_r == ST_START) begin
      rom_sel_r <= rom_s_r; // [R01]
    end
  end
  // memory setup burst only when not released under debug halt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_setup_start <= 1'b0;
    end else begin
      mem_setup_start <= (state_r == ST_START) && !dbg_s_r; // [R15]
    end
  end

  // byte counter, link lock and word assembly
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcnt_r     <= 2'd0;
      link_sel_r <= 2'd0;
      op_write_r <= 1'b0;
      addr_r     <= `BDEC_WORD_RST;
      data_r     <= `BDEC_WORD_RST;
      count_r    <= 8'h00;
      idx_r      <= 8'h00;
      byte_r     <= 8'h00;
    end else begin
      unique case (state_r)
        ST_CTRL: begin
          if (rx_fire) begin
            link_sel_r <= first_link; // [R10]
            op_write_r <= (rx_byte == `BDEC_CB_POKE);
            count_r    <= rx_byte; // [R05]
            idx_r      <= 8'h00;
            bcnt_r     <= 2'd0;
          end
        end
        ST_ADDR: begin
          if (rx_fire) begin
            addr_r <= {rx_byte, addr_r[31:8]}; // [R25]
            bcnt_r <= bcnt_r + 2'd1;
          end
        end
        ST_DATA: begin
          if (rx_fire) begin
            data_r <= {rx_byte, data_r[31:8]}; // [R25]
            bcnt_r <= bcnt_r + 2'd1;
          end
        end
        ST_READ: if (mem_ack) data_r <= mem_rdata; // [R09]
        ST_SEND: begin
          if (link_tx_ready) begin
            data_r <= {8'h00, data_r[31:8]}; // least significant byte goes first
            bcnt_r <= bcnt_r + 2'd1;
          end
        end
        ST_LOAD:  if (rx_fire) byte_r <= rx_byte;
        ST_STORE: if (mem_ack) idx_r <= idx_r + 8'd1; // [R05]
        default: begin
        end
      endcase
    end
  end

  // memory port; loaded bytes land in the lane of their own address
  assign mem_req   = (state_r == ST_WRITE) || (state_r == ST_READ) || (state_r == ST_STORE);
  assign mem_we    = (state_r == ST_WRITE) || (state_r == ST_STORE);
  assign mem_addr  = (state_r == ST_STORE) ? `BDEC_USER_BASE + {24'h00_0000, idx_r} // [R23]
                                           : addr_r;
  assign mem_be    = (state_r == ST_STORE) ? 4'h1 << mem_addr[1:0] : 4'hF; // [R24]
  assign mem_wdata = (state_r == ST_STORE) ? {4{byte_r}} : data_r; // [R08]

  // peek answer goes back on the link that asked
  assign link_tx_valid = (state_r == ST_SEND); // [R09]
  assign link_tx_link  = link_sel_r;
  assign link_tx_data  = data_r[7:0];

  // processor start values; workspace after a load begins at the next free word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_start    <= 1'b0;
      cpu_iptr_out <= `BDEC_USER_BASE;
      cpu_wptr_out <= `BDEC_USER_BASE;
    end else begin
      cpu_start <= 1'b0;
      if (state_r == ST_ROMWAIT && state_nxt == ST_RUN) begin
        cpu_start    <= 1'b1;
        cpu_iptr_out <= `BDEC_ROM_BOOT_ADDR; // [R02]
        cpu_wptr_out <= `BDEC_USER_BASE;     // [R03]
      end else if (state_r == ST_STORE && state_nxt == ST_RUN) begin
        cpu_start    <= 1'b1;
        cpu_iptr_out <= `BDEC_USER_BASE; // [R06]
        cpu_wptr_out <= (`BDEC_USER_BASE + {24'h00_0000, count_r} + 32'h0000_0003)
                        & 32'hFFFF_FFFC; // [R06]
      end
    end
  end

  assign cpu_low_priority = 1'b1; // boot always starts a low priority process [R03]

  // debug halt request is armed on a rising halt input while running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_pend_r <= 1'b0;
    end else if (state_r != ST_RUN) begin
      halt_pend_r <= 1'b0;
    end else if (dbg_s_r && !dbg_d_r) begin
      halt_pend_r <= 1'b1; // [R11]
    end
  end

  assign cpu_halt_request = halt_pend_r; // [R11]
  assign cpu_halt         = (state_r == ST_HALT);

  // while halted no link_rx_ready is raised, outputs stop fetching, refresh never stops
  assign refresh_enable        = 1'b1;                  // [R12] [R21]
  assign link_out_fetch_enable = (state_r != ST_HALT);  // [R13] [R21]

  // evaluation copies survive hresetn so software can inspect the halted machine
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      eval_a_r <= `BDEC_WORD_RST;
      eval_b_r <= `BDEC_WORD_RST;
      eval_c_r <= `BDEC_WORD_RST;
    end else begin
      if (fault_halt) begin
        eval_a_r <= cpu_instr_addr_in + `BDEC_IPTR_FAULT; // [R22] [R17]
        eval_b_r <= cpu_wdesc_in;                         // [R17]
      end else if (state_r == ST_RUN && halt_pend_r && cpu_desched) begin
        eval_a_r <= cpu_instr_addr_in + `BDEC_IPTR_DEBUG; // [R22] [R17]
        eval_b_r <= cpu_wdesc_in;                         // [R17]
      end
      if (state_r == ST_CTRL && rx_fire && rx_byte > `BDEC_CB_PEEK) begin
        eval_c_r <= {30'h0000_0000, first_link}; // [R17]
      end
    end
  end

endmodule

// ==== bdec_top_asserts.sv ====
// Purpose: port-level checks of bdec_top
// Assumes: one hclk domain, debug halt and rom select held around reset release
// Notes:   fault checks gate on por_n only
`timescale 1ns/10ps
module bdec_top_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        por_n,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rom_boot_select,
  input wire logic        debug_halt_in,
  input wire logic [3:0]  link_rx_ready,
  input wire logic        link_tx_valid,
  input wire logic [7:0]  link_tx_data,
  input wire logic        link_tx_ready,
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        mem_setup_start,
  input wire logic        refresh_enable,
  input wire logic        link_out_fetch_enable,
  input wire logic        cpu_start,
  input wire logic        cpu_halt,
  input wire logic        cpu_halt_request,
  input wire logic        cpu_desched,
  input wire logic        err_set_in,
  input wire logic        testerr_in,
  input wire logic        preempt_end_in,
  input wire logic        fault_indicator_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // bus slave never stalls and never errors
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not okay");
  a_link_early: assert property (
    $rose(hresetn) && !rom_boot_select |-> ##[1:2] (&link_rx_ready))
    else $error("late link ready");
  a_setup_skip: assert property (
    $rose(hresetn) && debug_halt_in |-> !mem_setup_start [*4])
    else $error("setup under halt");
  a_halt_quiet: assert property (
    cpu_halt |-> !link_out_fetch_enable && refresh_enable)
    else $error("halt fetch or refresh");
  a_halt_sticky: assert property (cpu_halt |=> cpu_halt)
    else $error("halt released");
  a_desched_stop: assert property (cpu_halt_request && cpu_desched |=> cpu_halt)
    else $error("no desched halt");
  a_tx_hold: assert property (
    link_tx_valid && !link_tx_ready |=> link_tx_valid && $stable(link_tx_data))
    else $error("tx byte changed");
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("mem request dropped");
  a_fault_clear: assert property (disable iff (!por_n)
    $fell(fault_indicator_out) |-> $past(testerr_in || preempt_end_in || hwdata[1]))
    else $error("fault pin fell");
  a_fault_raise: assert property (disable iff (!por_n)
    $rose(fault_indicator_out) |-> $past(err_set_in || preempt_end_in || hwdata[0]))
    else $error("fault pin rose");
  c_boot_start: cover property (cpu_start);
  c_halted: cover property ($rose(cpu_halt));
  c_peek_byte: cover property (link_tx_valid && link_tx_ready);
endmodule

// ==== bdec_far_model.sv ====
// Purpose: memory and link-output partner of bdec_top
// Assumes: one access at a time, ack is a one-cycle pulse
// Notes:   slow mode adds wait cycles and drops link_tx_ready every other cycle
`timescale 1ns/10ps
module bdec_far_model (
  input  wire logic        hclk,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  mem_be,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack,
  output logic             link_tx_ready
);
  logic [7:0]  mem [logic [31:0]];
  logic [3:0]  wait_r = '0;
  wire  [31:0] w = {mem_addr[31:2], 2'b00};
  initial mem_ack = 1'b0;
  initial mem_rdata = '0;
  initial link_tx_ready = 1'b1;
  // unwritten bytes read as zero
  function automatic logic [7:0] rdb(input logic [31:0] ad);
    return mem.exists(ad) ? mem[ad] : 8'h00;
  endfunction
  // access ends at the edge that sees ack; idle data toggles
  always @(posedge hclk) begin
    link_tx_ready <= slow ? ~link_tx_ready : 1'b1;
    mem_rdata <= ~mem_rdata;
    mem_ack <= 1'b0;
    if (mem_req && mem_ack) begin
      wait_r <= '0;
      for (int i = 0; i < 4; i++)
        if (mem_we && mem_be[i]) mem[w + i] = mem_wdata[8*i +: 8];
    end else if (mem_req && wait_r == (slow ? 4'h5 : 4'h0)) begin
      mem_ack <= 1'b1;
      mem_rdata <= {rdb(w + 3), rdb(w + 2), rdb(w + 1), rdb(w)};
    end else if (mem_req) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// ==== bdec_top_tb.sv ====
// Purpose: self-checking bench of bdec_top against a memory and link far side
// Assumes: bus answers every transfer; link bytes taken on valid and ready
// Notes:   expectations come from the rules, not the design
`timescale 1ns/10ps
`include "bdec_regs.svh"
module bdec_top_tb;
  import bdec_pkg::*;
  localparam logic [31:0] BASE = `BDEC_USER_BASE;
  logic        hclk = 0, hresetn = 0, por_n = 0, hsel = 0, hwrite = 0, slow = 0;
  logic        rom_boot_select = 0, debug_halt_in = 0;
  logic [7:0]  haddr = '0;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  link_rx_valid = '0;
  logic [6:0]  ev = '0;
  logic [31:0] hwdata = '0, link_rx_data = '0, cpu_instr_addr_in = '0, cpu_wdesc_in = '0;
  wire logic   hready, cpu_desched, preempt_end_in, preempt_in, hof_clr_in, hof_set_in;
  wire logic   testerr_in, err_set_in;
  logic        hreadyout, hresp, link_tx_valid, link_tx_ready, mem_req, mem_we, mem_ack;
  logic        mem_setup_start, refresh_enable, link_out_fetch_enable, cpu_start, cpu_halt;
  logic        cpu_halt_request, cpu_low_priority, fault_indicator_out;
  logic [1:0]  link_tx_link;
  logic [7:0]  link_tx_data;
  logic [3:0]  link_rx_ready, mem_be;
  logic [31:0] hrdata, mem_rdata, mem_addr, mem_wdata, cpu_iptr_out, cpu_wptr_out;
  logic [31:0] st_iptr, st_wptr, rd, a, d;
  logic [63:0] pl;
  logic [9:0]  txq [$];
  int          errors = 0, num_checks = 0, seed = 7, setups = 0, starts = 0;
  always #5 hclk = ~hclk;
  // one slave: its ready is the bus ready
  assign hready = hreadyout;
  assign {cpu_desched, preempt_end_in, preempt_in, hof_clr_in, hof_set_in, testerr_in,
          err_set_in} = ev;
  bdec_top DUT (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
    .hwdata, .hrdata, .hreadyout, .hresp, .rom_boot_select, .debug_halt_in, .link_rx_valid,
    .link_rx_data, .link_rx_ready, .link_tx_valid, .link_tx_link, .link_tx_data,
    .link_tx_ready, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_rdata, .mem_ack,
    .mem_setup_start, .refresh_enable, .link_out_fetch_enable, .cpu_start, .cpu_halt,
    .cpu_halt_request, .cpu_low_priority, .cpu_iptr_out, .cpu_wptr_out, .cpu_desched,
    .cpu_instr_addr_in, .cpu_wdesc_in, .err_set_in, .testerr_in, .hof_set_in, .hof_clr_in,
    .preempt_in, .preempt_end_in, .fault_indicator_out);
  bdec_far_model u_far (.hclk, .slow, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata,
    .mem_rdata, .mem_ack, .link_tx_ready);
  // log tx bytes, setup pulses, starts
  always @(posedge hclk) begin
    if (link_tx_valid && link_tx_ready) txq.push_back({link_tx_link, link_tx_data});
    if (mem_setup_start) setups++;
    if (cpu_start) begin
      starts++;
      st_iptr = cpu_iptr_out;
      st_wptr = cpu_wptr_out;
    end
  end
  task automatic stop_test();
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // one word; read data taken at end of data phase
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, ad, w};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // control byte then n bytes, least significant first
  task automatic send(input int l, input logic [7:0] c, input logic [63:0] p, input int n);
    logic [7:0] b;
    @(posedge hclk);
    for (int i = -1; i < n; i++) begin
      b = (i < 0) ? c : p[8*i +: 8];
      link_rx_valid[l] <= 1'b1;
      link_rx_data[8*l +: 8] <= b;
      do @(posedge hclk); while (link_rx_ready[l] !== 1'b1);
    end
    link_rx_valid[l] <= 1'b0;
    link_rx_data[8*l +: 8] <= ~b;
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge hclk);
    ev <= m;
    @(posedge hclk);
    ev <= '0;
    repeat (2) @(posedge hclk);
  endtask
  task automatic wait_state(input logic [3:0] st);
    for (int i = 0; i < 100; i++) begin
      ahb(1'b0, `BDEC_OFS_STATUS, '0);
      if (rd[3:0] === st) break;
    end
    chk("state", st, rd[3:0]);
  endtask
  task automatic wait_start(input int s);
    for (int i = 0; i < 300 && starts == s; i++) @(posedge hclk);
    chk("start count", s + 1, starts);
  endtask
  // pins lead release: they pass a synchroniser
  task automatic do_reset(input logic rom, input logic halt);
    @(posedge hclk);
    {rom_boot_select, debug_halt_in, hresetn} <= {rom, halt, 1'b0};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge hclk);
    {por_n, hresetn} <= 2'b11;
    a = BASE + 32'h0000_0190;
    d = $random(seed);
    send(0, `BDEC_CB_POKE, {d, a}, 8);
    wait_state(ST_CTRL);
    chk("poked word", d, {u_far.rdb(a+3), u_far.rdb(a+2), u_far.rdb(a+1), u_far.rdb(a)});
    slow <= 1'b1;
    send(2, `BDEC_CB_PEEK, {32'h0, a}, 4);
    for (int i = 0; i < 400 && txq.size() < 4; i++) @(posedge hclk);
    for (int i = 0; i < 4; i++) chk("peek byte", {2'd2, d[8*i +: 8]}, txq.pop_front());
    ahb(1'b0, 8'h40, '0);
    chk("unmapped read", '0, rd);
    wait_state(ST_CTRL);
    pl = {$random(seed), $random(seed)};
    send(1, 8'h05, pl, 5);
    wait_start(0);
    for (int i = 0; i < 5; i++) chk("loaded byte", pl[8*i +: 8], u_far.rdb(BASE + i));
    chk("load iptr", BASE, st_iptr);
    chk("load wptr", (BASE + 32'h8) & 32'hFFFF_FFFC, st_wptr);
    ahb(1'b0, `BDEC_OFS_EVAL_C, '0);
    chk("boot link", 32'h1, rd);
    cpu_instr_addr_in <= $random(seed);
    pulse(7'h01);
    chk("fault pin", 1'b1, fault_indicator_out);
    pulse(7'h04);
    chk("late hof halt", 1'b0, cpu_halt);
    pulse(7'h02);
    chk("fault pin", 1'b0, fault_indicator_out);
    pulse(7'h01);
    chk("fault halt", 1'b1, cpu_halt);
    chk("output fetch", 1'b0, link_out_fetch_enable);
    ahb(1'b0, `BDEC_OFS_EVAL_A, '0);
    chk("fault pointer", cpu_instr_addr_in + 32'h2, rd);
    do_reset(1'b1, 1'b0);
    @(posedge hclk);
    rom_boot_select <= 1'b0;
    wait_start(1);
    chk("rom iptr", 32'h7FFF_FFFE, st_iptr);
    chk("rom wptr", BASE, st_wptr);
    chk("low priority", 1'b1, cpu_low_priority);
    chk("memory setups", 2, setups);
    ahb(1'b0, `BDEC_OFS_STATUS, '0);
    chk("flags kept", 2'b11, rd[7:6]);
    pulse(7'h10);
    ahb(1'b0, `BDEC_OFS_STATUS, '0);
    chk("preempt flags", 2'b01, rd[7:6]);
    pulse(7'h20);
    ahb(1'b0, `BDEC_OFS_STATUS, '0);
    chk("restored flags", 2'b11, rd[7:6]);
    pulse(7'h0A);
    d = $random(seed);
    cpu_wdesc_in <= d;
    debug_halt_in <= 1'b1;
    for (int i = 0; i < 20 && cpu_halt_request !== 1'b1; i++) @(posedge hclk);
    chk("halt pending", 1'b1, cpu_halt_request);
    pulse(7'h40);
    chk("debug halt", 1'b1, cpu_halt);
    ahb(1'b0, `BDEC_OFS_EVAL_A, '0);
    chk("eval a", cpu_instr_addr_in + 32'h1, rd);
    ahb(1'b0, `BDEC_OFS_EVAL_B, '0);
    chk("eval b", d, rd);
    do_reset(1'b1, 1'b1);
    repeat (20) @(posedge hclk);
    chk("setup skipped", 2, setups);
    chk("boot held", 2, starts);
    debug_halt_in <= 1'b0;
    wait_start(2);
    chk("rom iptr again", 32'h7FFF_FFFE, st_iptr);
    stop_test();
  end
endmodule
bind bdec_top bdec_top_asserts u_chk (.hclk, .hresetn, .por_n, .hwdata, .hreadyout, .hresp,
  .rom_boot_select, .debug_halt_in, .link_rx_ready, .link_tx_valid, .link_tx_data,
  .link_tx_ready, .mem_req, .mem_addr, .mem_ack, .mem_setup_start, .refresh_enable,
  .link_out_fetch_enable, .cpu_start, .cpu_halt, .cpu_halt_request, .cpu_desched,
  .err_set_in, .testerr_in, .preempt_end_in, .fault_indicator_out);
